/* File: gpp_port.v */
// general-purpose bidirectional port with i/o-space registers
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.vh"
module gpp_port #(
  parameter WIDTH = 8,
  parameter [`GPP_ADDR_W-1:0] ADDR_PIN = `GPP_ADDR_PIN_SENSE,
  parameter [`GPP_ADDR_W-1:0] ADDR_DIR = `GPP_ADDR_DIRECTION,
  parameter [`GPP_ADDR_W-1:0] ADDR_OUT = `GPP_ADDR_OUT_LATCH
) (
  input wire clk,
  input wire arst_n,
  input wire [`GPP_ADDR_W-1:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire [WIDTH-1:0] pad_in,
  output wire [WIDTH-1:0] pad_out,
  output wire [WIDTH-1:0] pad_oe_n,
  output wire [WIDTH-1:0] pad_pullup,
  input wire [WIDTH-1:0] alt_en,
  input wire [WIDTH-1:0] alt_out,
  input wire [WIDTH-1:0] alt_oe,
  output wire global_pullup_off
);
  // ==========================================================
  // registers
  reg [WIDTH-1:0] port_output_latch;
  reg [WIDTH-1:0] port_direction;
  reg [7:0] mcu_control;
  wire [WIDTH-1:0] port_pin_sense;
  wire wr_out;
  wire wr_dir;
  wire wr_pin;
  wire wr_mcu;

  assign wr_out = io_wr && (io_addr == ADDR_OUT);
  assign wr_dir = io_wr && (io_addr == ADDR_DIR);
  assign wr_pin = io_wr && (io_addr == ADDR_PIN);
  assign wr_mcu = io_wr && (io_addr == `GPP_ADDR_MCU_CTRL);
  assign global_pullup_off = mcu_control[`GPP_MCU_PUD_BIT];

  // a set/clear instruction arrives as a whole-byte write of the
  // read-modified value, so each bit updates on its own
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_output_latch <= `GPP_PORT_RESET >> (8 - WIDTH);
      port_direction <= `GPP_PORT_RESET >> (8 - WIDTH);
      mcu_control <= `GPP_MCU_RESET;
    end else begin
      if (wr_out) begin
        port_output_latch <= io_wdata[WIDTH-1:0];
      end else if (wr_pin) begin
        // toggle ones, keep zeros
        port_output_latch <= port_output_latch
          ^ io_wdata[WIDTH-1:0];
      end
      if (wr_dir) begin
        port_direction <= io_wdata[WIDTH-1:0];
      end
      if (wr_mcu) begin
        // only the pull-up disable is writable here
        mcu_control <= io_wdata & `GPP_MCU_RW_MASK;
      end
    end
  end

  // ==========================================================
  // pins
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      gpp_pin_ctrl u_pin (
        .arst_n(arst_n),
        .dir_bit(port_direction[i]),
        .out_latch_bit(port_output_latch[i]),
        .global_pullup_off(global_pullup_off),
        .alt_en(alt_en[i]),
        .alt_out(alt_out[i]),
        .alt_oe(alt_oe[i]),
        .pad_out(pad_out[i]),
        .pad_oe_n(pad_oe_n[i]),
        .pad_pullup(pad_pullup[i])
      );
    end
  endgenerate

  // ==========================================================
  // input sampling; loop-back delay follows from the two stages
  gpp_sync #(.WIDTH(WIDTH)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(pad_in),
    .dout(port_pin_sense)
  );

  // ==========================================================
  // read mux; three port addresses plus the control byte
  always @* begin
    io_rdata = 8'h00;
    if (io_rd && io_addr == ADDR_PIN) begin
      io_rdata[WIDTH-1:0] = port_pin_sense;
    end else if (io_rd && io_addr == ADDR_DIR) begin
      io_rdata[WIDTH-1:0] = port_direction;
    end else if (io_rd && io_addr == ADDR_OUT) begin
      io_rdata[WIDTH-1:0] = port_output_latch;
    end else if (io_rd && io_addr == `GPP_ADDR_MCU_CTRL) begin
      io_rdata = mcu_control;
    end
  end
endmodule // gpp_port
`default_nettype wire

/* File: gpp_consts.vh */
// constants for the general-purpose port block
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH
// i/o space addresses (no printed offsets; chosen locally)
`define GPP_ADDR_PIN_SENSE 6'h03
`define GPP_ADDR_DIRECTION 6'h04
`define GPP_ADDR_OUT_LATCH 6'h05
`define GPP_ADDR_MCU_CTRL 6'h35
// mcu control field positions, reset values and address width
`define GPP_MCU_PUD_BIT 4
`define GPP_MCU_RW_MASK 8'h10
`define GPP_MCU_RESET 8'h00
`define GPP_PORT_RESET 8'h00
`define GPP_ADDR_W 6
`endif

/* File: gpp_sync.v */
// two-stage input synchroniser for one port's pins
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;
  // first stage read only by the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // gpp_sync
`default_nettype wire

/* File: gpp_pin_ctrl.v */
// per-pin driver, enable and pull-up decode
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_ctrl (
  input wire arst_n,
  input wire dir_bit,
  input wire out_latch_bit,
  input wire global_pullup_off,
  input wire alt_en,
  input wire alt_out,
  input wire alt_oe,
  output wire pad_out,
  output wire pad_oe_n,
  output wire pad_pullup
);
  wire drive;
  assign drive = alt_en ? alt_oe : dir_bit;
  // reset gates the drivers directly: no clock needed
  assign pad_oe_n = ~(drive & arst_n);
  assign pad_out = alt_en ? alt_out : out_latch_bit;
  assign pad_pullup = arst_n & ~drive & out_latch_bit
    & ~global_pullup_off;
endmodule // gpp_pin_ctrl
`default_nettype wire

/* File: gpp_port_sva.sv */
// assertion checker for the general-purpose port
`timescale 1ns/1ps
`default_nettype none
module gpp_port_sva (
  input wire clk,
  input wire arst_n,
  input wire io_wr,
  input wire [5:0] io_addr,
  input wire [7:0] io_wdata,
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe_n,
  input wire [7:0] pad_pullup,
  input wire global_pullup_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(a);
    io_wr && io_addr == a;
  endsequence
  chk_reset_hiz: assert property (disable iff (1'b0)
    !arst_n |-> &pad_oe_n && !pad_pullup) else $error("rst pads");
  chk_dir_out: assert property (s_wr(6'h04) |=>
    pad_oe_n == ~$past(io_wdata)) else $error("dir");
  chk_drive_val: assert property (s_wr(6'h05) |=>
    pad_out == $past(io_wdata)) else $error("drive");
  chk_toggle_bits: assert property (s_wr(6'h03) |=>
    pad_out == ($past(pad_out) ^ $past(io_wdata))) else $error("tog");
  chk_pullup_dec: assert property (pad_pullup ==
    (pad_oe_n & pad_out & {8{!global_pullup_off}})) else $error("pu");
  chk_pud_all: assert property (global_pullup_off |->
    pad_pullup == 8'h00) else $error("pud");
  chk_pud_write: assert property (s_wr(6'h35) |=>
    global_pullup_off == $past(io_wdata[4])) else $error("mcu");
  chk_hold_idle: assert property (!io_wr |=>
    $stable(pad_out) && $stable(pad_oe_n)) else $error("hold");
endmodule // gpp_port_sva
bind gpp_port gpp_port_sva u_sva (.*);
`default_nettype wire

/* File: gpp_pads.sv */
// board-side model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module gpp_pads (
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  // the board drives every pin that neither the port nor a pull-up holds
  assign pad_in = ~pad_oe_n & pad_out | pad_oe_n & pad_pullup
    | pad_oe_n & ~pad_pullup & ext_val;
endmodule // gpp_pads
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the general-purpose port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, arst_n = 0, io_wr = 0, io_rd = 0;
  logic [5:0] io_addr = 0;
  logic [7:0] io_wdata = 0, ext_val = 0, d, l, t, u, pu;
  wire [7:0] io_rdata, pad_in, pad_out, pad_oe_n, pad_pullup;
  wire gpo;
  int err_count = 0, n_tests = 0;
  gpp_port dut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .alt_en(8'h00), .alt_out(8'h00),
    .alt_oe(8'h00), .global_pullup_off(gpo));
  gpp_pads pads (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .ext_val(ext_val), .pad_in(pad_in));
  initial forever #4 clk = ~clk;
  task close_out;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task ck(input string nm, input logic [7:0] e, s);
    n_tests++;
    if (e !== s) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    io_wr <= 1;
    io_addr <= a;
    io_wdata <= v;
    @(posedge clk);
    io_wr <= 0;
    #1;
  endtask
  task rd(input logic [5:0] a, input string nm, input logic [7:0] e);
    @(posedge clk);
    io_rd <= 1;
    io_addr <= a;
    #1 ck(nm, e, io_rdata);
  endtask
  initial begin
    #20000;
    err_count++;
    close_out;
  end
  initial begin
    d = $urandom(89818);
    repeat (5) @(posedge clk);
    ck("oe_rst", 8'hFF, pad_oe_n);
    arst_n <= 1;
    rd(6'h35, "mcu", 8'h00);
    wr(6'h35, 8'hFF);
    rd(6'h35, "mcu_rw", 8'h10);
    rd(6'h3F, "unmapped", 8'h00);
    // first passes hit all-ones and all-zero corners, then random
    for (int i = 0; i < 40; i++) begin
      d = i < 2 ? {8{i[0]}} : 8'($urandom);
      l = i < 2 ? 8'hFF : 8'($urandom);
      t = $urandom;
      u = $urandom;
      ext_val <= $urandom;
      wr(6'h35, {3'h0, u[0], 4'h0});
      wr(6'h04, d);
      wr(6'h05, l);
      wr(6'h03, t);
      l = l ^ t;
      pu = ~d & l & {8{~u[0]}};
      ck("oe_n", ~d, pad_oe_n);
      ck("latch", l, pad_out);
      ck("pullup", pu, pad_pullup);
      rd(6'h04, "dir", d);
      rd(6'h05, "lat", l);
      rd(6'h03, "pin", d & l | pu | ~d & ~pu & ext_val);
    end
    @(posedge clk);
    arst_n <= 0;
    #1 ck("oe_async", 8'hFF, pad_oe_n);
    ck("pu_async", 8'h00, pad_pullup);
    close_out;
  end
endmodule // tb
`default_nettype wire
